/* File: rtl/meter_regs.v */
// Register bank of the metering core: peaks, overcurrent flags, filter and mode registers.
// Assumes the serial port front end presents decoded word accesses synchronous to ref_clk.
`timescale 1ns/1ps
`include "meter_regs_defines.vh"
module meter_regs #(
   parameter [7:0] VERSION_ID = 8'h01,
   parameter [7:0] PROTECT_KEY = 8'h5A,
   parameter CW = 8
) (
   input wire ref_clk,
   input wire rstn,
   input wire [`ADDR_W-1:0] reg_addr,
   input wire reg_wr,
   input wire reg_rd,
   input wire [`DATA_W-1:0] reg_wdata,
   output reg [`DATA_W-1:0] reg_rdata_q,
   output reg reg_rvalid_q,
   input wire [6*`MAG_W-1:0] cur_mag,
   input wire cur_valid,
   input wire [`MAG_W-1:0] volt_mag,
   input wire volt_valid,
   input wire [6*`MAG_W-1:0] cur_wave,
   input wire [`MAG_W-1:0] volt_wave,
   input wire half_cycle,
   input wire [5:0] oc_event,
   input wire [15:0] power_sign_flags,
   input wire spi_active,
   input wire ack_pin_i,
   output reg ack_pin_o_q,
   output reg ack_pin_oe_q,
   output reg hpf_bypass_q,
   output reg group_sel_q,
   output reg [15:0] configuration_q,
   output reg [7:0] measurement_mode_q,
   output reg [7:0] accumulation_mode_q,
   output reg [7:0] line_cycle_accum_mode_q,
   output reg [7:0] sag_half_cycle_count_q,
   output reg [7:0] capture_port_config_q,
   output reg [7:0] secondary_configuration_q,
   output reg soft_reset_q
);
   reg [23:0] highpass_filter_disable_q;
   reg [15:0] computation_mode_q;
   reg [7:0] peak_half_cycle_count_q;
   reg [7:0] version_q;
   reg [7:0] register_protection_q;
   reg key_armed_q;
   reg [`DATA_W-1:0] rdata_d;

   wire [3*`MAG_W-1:0] grp_mag;
   wire [3*`MAG_W-1:0] grp_wave;
   wire [2:0] grp_oc;
   wire [`MAG_W-1:0] current_peak_magnitude;
   wire [2:0] peak_src;
   wire [`MAG_W-1:0] voltage_peak_magnitude;
   wire [2:0] oc_src;
   wire locked;
   wire wr_ok;
   wire oc_clear;

   // Pads a 24-bit value with zeros to the 32-bit transfer word.
   function [`DATA_W-1:0] zero_pad24;
      input [23:0] v;
      begin
         zero_pad24 = {8'h00, v};
      end
   endfunction

   // Pads a 20-bit value with zeros to the 32-bit transfer word.
   function [`DATA_W-1:0] zero_pad20;
      input [19:0] v;
      begin
         zero_pad20 = {12'h000, v};
      end
   endfunction

   // Extends a two's complement 24-bit value to the 32-bit transfer word.
   function [`DATA_W-1:0] sign_ext24;
      input [23:0] v;
      begin
         sign_ext24 = {{8{v[23]}}, v};
      end
   endfunction

   // Picks the three channels of the active group out of six.
   function [3*`MAG_W-1:0] pick_group;
      input [6*`MAG_W-1:0] all;
      input sel;
      begin
         if (sel) begin
            pick_group = all[6*`MAG_W-1:3*`MAG_W];
         end else begin
            pick_group = all[3*`MAG_W-1:0];
         end
      end
   endfunction

   assign grp_mag = pick_group(cur_mag, group_sel_q);
   assign grp_wave = pick_group(cur_wave, group_sel_q);
   assign grp_oc = group_sel_q ? oc_event[5:3] : oc_event[2:0];

   assign locked = register_protection_q[`PROTECT_LOCK_BIT];
   assign wr_ok = reg_wr && !locked;
   assign oc_clear = reg_rd && (reg_addr == `A_OC_FLAGS);

   peak_tracker #(
      .W(`MAG_W),
      .N(3),
      .CW(CW)
   ) u_cur_peak (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .clear(soft_reset_q),
      .sample_valid(cur_valid),
      .mags(grp_mag),
      .half_cycle(half_cycle),
      .interval(peak_half_cycle_count_q),
      .peak_q(current_peak_magnitude),
      .src_q(peak_src)
   );

   peak_tracker #(
      .W(`MAG_W),
      .N(1),
      .CW(CW)
   ) u_volt_peak (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .clear(soft_reset_q),
      .sample_valid(volt_valid),
      .mags(volt_mag),
      .half_cycle(half_cycle),
      .interval(peak_half_cycle_count_q),
      .peak_q(voltage_peak_magnitude),
      .src_q()
   );

   oc_flags #(
      .N(3)
   ) u_oc (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .clear(oc_clear),
      .events(grp_oc),
      .flags_q(oc_src)
   );

   // Read mux. Values that are not ours to define read as zero.
   always @* begin
      rdata_d = {`DATA_W{1'b0}};
      case (reg_addr)
         `A_HPF_DISABLE: rdata_d = zero_pad24(highpass_filter_disable_q);
         `A_CUR_PEAK: rdata_d = {5'h00, peak_src, current_peak_magnitude};
         `A_VOLT_PEAK: rdata_d = zero_pad24(voltage_peak_magnitude);
         `A_WAVE_FIRST: rdata_d = sign_ext24(grp_wave[`MAG_W-1:0]);
         `A_WAVE_SECOND: rdata_d = sign_ext24(grp_wave[2*`MAG_W-1:`MAG_W]);
         `A_WAVE_THIRD: rdata_d = sign_ext24(grp_wave[3*`MAG_W-1:2*`MAG_W]);
         `A_WAVE_VOLT: rdata_d = sign_ext24(volt_wave);
         `A_OC_FLAGS: rdata_d = {26'h000_0000, oc_src, 3'h0};
         `A_COMP_MODE: rdata_d = {16'h0000, computation_mode_q};
         `A_POWER_SIGN: rdata_d = {16'h0000, power_sign_flags};
         `A_CONFIG: rdata_d = {16'h0000, configuration_q};
         `A_MEAS_MODE: rdata_d = {24'h00_0000, measurement_mode_q};
         `A_ACCUM_MODE: rdata_d = {24'h00_0000, accumulation_mode_q};
         `A_LCYC_MODE: rdata_d = {24'h00_0000, line_cycle_accum_mode_q};
         `A_PEAK_CYC: rdata_d = {24'h00_0000, peak_half_cycle_count_q};
         `A_SAG_CYC: rdata_d = {24'h00_0000, sag_half_cycle_count_q};
         `A_CAPT_CFG: rdata_d = {24'h00_0000, capture_port_config_q};
         `A_VERSION: rdata_d = {24'h00_0000, version_q};
         `A_PROTECT: rdata_d = {24'h00_0000, register_protection_q};
         `A_PIN_CTRL: rdata_d = {30'h0000_0000, ack_pin_oe_q, ack_pin_i};
         `A_SECONDARY_CONFIGURATION: rdata_d = {24'h00_0000, secondary_configuration_q};
         default: rdata_d = {`DATA_W{1'b0}};
      endcase
   end

   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata_q <= {`DATA_W{1'b0}};
         reg_rvalid_q <= 1'b0;
      end else begin
         reg_rvalid_q <= reg_rd;
         if (reg_rd) begin
            reg_rdata_q <= rdata_d;
         end
      end
   end

   // The key must be the write just before the protection write; any other write disarms it.
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         key_armed_q <= 1'b0;
         register_protection_q <= `RST_PROTECT;
      end else if (soft_reset_q) begin
         key_armed_q <= 1'b0;
         register_protection_q <= `RST_PROTECT;
      end else if (reg_wr) begin
         key_armed_q <= (reg_addr == `A_PROTECT_KEY) && (reg_wdata[7:0] == PROTECT_KEY);
         if ((reg_addr == `A_PROTECT) && key_armed_q) begin
            register_protection_q <= reg_wdata[7:0];
         end
      end
   end

   // Pin control is only honoured while SPI owns the port.
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         ack_pin_o_q <= 1'b0;
         ack_pin_oe_q <= 1'b0;
      end else if (!spi_active) begin
         ack_pin_oe_q <= 1'b0;
      end else if (reg_wr && (reg_addr == `A_PIN_CTRL)) begin
         ack_pin_o_q <= reg_wdata[`PIN_LEVEL_BIT];
         ack_pin_oe_q <= reg_wdata[`PIN_DRIVE_BIT];
      end
   end

   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         soft_reset_q <= 1'b0;
      end else begin
         soft_reset_q <= wr_ok && (reg_addr == `A_CONFIG) && reg_wdata[`SOFT_RST_BIT];
      end
   end

   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         highpass_filter_disable_q <= `RST_HPF_DISABLE;
         hpf_bypass_q <= 1'b0;
         computation_mode_q <= `RST_COMP_MODE;
         group_sel_q <= 1'b0;
         configuration_q <= `RST_CONFIG;
         measurement_mode_q <= `RST_MEAS_MODE;
         accumulation_mode_q <= `RST_ACCUM_MODE;
         line_cycle_accum_mode_q <= `RST_LCYC_MODE;
         peak_half_cycle_count_q <= `RST_PEAK_CYC;
         sag_half_cycle_count_q <= `RST_SAG_CYC;
         capture_port_config_q <= `RST_CAPT_CFG;
         version_q <= 8'h00;
         secondary_configuration_q <= `RST_SECONDARY_CONFIGURATION;
      end else if (soft_reset_q) begin
         highpass_filter_disable_q <= `RST_HPF_DISABLE;
         hpf_bypass_q <= 1'b0;
         computation_mode_q <= `RST_COMP_MODE;
         group_sel_q <= 1'b0;
         configuration_q <= `RST_CONFIG;
         measurement_mode_q <= `RST_MEAS_MODE;
         accumulation_mode_q <= `RST_ACCUM_MODE;
         line_cycle_accum_mode_q <= `RST_LCYC_MODE;
         peak_half_cycle_count_q <= `RST_PEAK_CYC;
         sag_half_cycle_count_q <= `RST_SAG_CYC;
         capture_port_config_q <= `RST_CAPT_CFG;
         version_q <= VERSION_ID;
         secondary_configuration_q <= `RST_SECONDARY_CONFIGURATION;
      end else begin
         // The strap-like version value is loaded after reset release and whenever the register holds zero.
         if (version_q == 8'h00) begin
            version_q <= VERSION_ID;
         end
         hpf_bypass_q <= (highpass_filter_disable_q != 24'h00_0000);
         group_sel_q <= computation_mode_q[`GROUP_SEL_BIT];
         if (wr_ok) begin
            case (reg_addr)
               `A_HPF_DISABLE: highpass_filter_disable_q <= reg_wdata[23:0];
               `A_COMP_MODE: computation_mode_q <= reg_wdata[15:0];
               `A_CONFIG: configuration_q <= {reg_wdata[15:8], 1'b0, reg_wdata[6:0]};
               `A_MEAS_MODE: measurement_mode_q <= reg_wdata[7:0];
               `A_ACCUM_MODE: accumulation_mode_q <= reg_wdata[7:0];
               `A_LCYC_MODE: line_cycle_accum_mode_q <= reg_wdata[7:0];
               `A_PEAK_CYC: peak_half_cycle_count_q <= reg_wdata[7:0];
               `A_SAG_CYC: sag_half_cycle_count_q <= reg_wdata[7:0];
               `A_CAPT_CFG: capture_port_config_q <= reg_wdata[7:0];
               `A_VERSION: version_q <= reg_wdata[7:0];
               `A_SECONDARY_CONFIGURATION: secondary_configuration_q <= reg_wdata[7:0];
               default: begin
               end
            endcase
         end
      end
   end
endmodule // meter_regs

/* File: rtl/meter_regs_defines.vh */
// Register addresses, field positions and reset values of the meter register bank.
// Included by the register bank only; the host model, checker and testbench write the addresses as literals.
`ifndef METER_REGS_DEFINES_VH
`define METER_REGS_DEFINES_VH

`define ADDR_W 16
`define DATA_W 32
`define MAG_W 24

`define A_HPF_DISABLE 16'h4389
`define A_CUR_PEAK 16'hE500
`define A_VOLT_PEAK 16'hE501
`define A_WAVE_FIRST 16'hE50C
`define A_WAVE_SECOND 16'hE50D
`define A_WAVE_THIRD 16'hE50E
`define A_WAVE_VOLT 16'hE510
`define A_OC_FLAGS 16'hE600
`define A_COMP_MODE 16'hE60E
`define A_RSVD_GAP_LO 16'hE610
`define A_RSVD_GAP_HI 16'hE616
`define A_POWER_SIGN 16'hE617
`define A_CONFIG 16'hE618
`define A_MEAS_MODE 16'hE700
`define A_ACCUM_MODE 16'hE701
`define A_LCYC_MODE 16'hE702
`define A_PEAK_CYC 16'hE703
`define A_SAG_CYC 16'hE704
`define A_CAPT_CFG 16'hE706
`define A_VERSION 16'hE707
`define A_PROTECT 16'hE7E3
`define A_PROTECT_KEY 16'hE7FE
`define A_PIN_CTRL 16'hEBFF
`define A_SECONDARY_CONFIGURATION 16'hEC00

`define RST_HPF_DISABLE 24'h00_0000
`define RST_COMP_MODE 16'h01FF
`define RST_CONFIG 16'h0000
`define RST_MEAS_MODE 8'h1C
`define RST_ACCUM_MODE 8'h00
`define RST_LCYC_MODE 8'h78
`define RST_PEAK_CYC 8'h00
`define RST_SAG_CYC 8'h00
`define RST_CAPT_CFG 8'h00
`define RST_PROTECT 8'h00
`define RST_SECONDARY_CONFIGURATION 8'h00

`define SRC_FLAG_LSB 24
`define OC_FLAG_LSB 3
`define GROUP_SEL_BIT 14
`define SOFT_RST_BIT 7
`define PROTECT_LOCK_BIT 0
`define PIN_LEVEL_BIT 0
`define PIN_DRIVE_BIT 1

`endif

/* File: rtl/peak_tracker.v */
// Peak magnitude tracker over a programmable count of half line cycles.
// Assumes magnitudes, sample strobe and half-cycle strobe are synchronous to ref_clk.
`timescale 1ns/1ps
module peak_tracker #(
   parameter W = 24,
   parameter N = 3,
   parameter CW = 8
) (
   input wire ref_clk,
   input wire rstn,
   input wire clear,
   input wire sample_valid,
   input wire [N*W-1:0] mags,
   input wire half_cycle,
   input wire [CW-1:0] interval,
   output reg [W-1:0] peak_q,
   output reg [N-1:0] src_q
);
   reg [W-1:0] run_max_q;
   reg [N-1:0] run_src_q;
   reg [CW-1:0] hc_cnt_q;
   reg [W-1:0] best;
   reg [N-1:0] best_src;
   wire running;
   wire end_iv;
   integer i;

   assign running = (interval != {CW{1'b0}});
   assign end_iv = half_cycle && running && (hc_cnt_q == interval - {{(CW-1){1'b0}}, 1'b1});

   always @* begin
      best = run_max_q;
      best_src = run_src_q;
      if (sample_valid) begin
         for (i = 0; i < N; i = i + 1) begin
            if (mags[i*W +: W] > best) begin
               best = mags[i*W +: W];
               best_src = {{(N-1){1'b0}}, 1'b1} << i;
            end
         end
      end
   end

   // Value and source flags load in the same edge so a read never mixes captures.
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         peak_q <= {W{1'b0}};
         src_q <= {N{1'b0}};
         run_max_q <= {W{1'b0}};
         run_src_q <= {N{1'b0}};
         hc_cnt_q <= {CW{1'b0}};
      end else if (clear) begin
         peak_q <= {W{1'b0}};
         src_q <= {N{1'b0}};
         run_max_q <= {W{1'b0}};
         run_src_q <= {N{1'b0}};
         hc_cnt_q <= {CW{1'b0}};
      end else if (end_iv) begin
         peak_q <= best;
         src_q <= best_src;
         run_max_q <= {W{1'b0}};
         run_src_q <= {N{1'b0}};
         hc_cnt_q <= {CW{1'b0}};
      end else begin
         run_max_q <= best;
         run_src_q <= best_src;
         if (half_cycle && running) begin
            hc_cnt_q <= hc_cnt_q + {{(CW-1){1'b0}}, 1'b1};
         end
      end
   end
endmodule // peak_tracker

/* File: rtl/oc_flags.v */
// Sticky per-channel overcurrent source flags.
// Assumes event pulses and the clear pulse are synchronous to ref_clk.
`timescale 1ns/1ps
module oc_flags #(
   parameter N = 3
) (
   input wire ref_clk,
   input wire rstn,
   input wire clear,
   input wire [N-1:0] events,
   output reg [N-1:0] flags_q
);
   // An event in the clearing cycle survives, so no overcurrent is lost.
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         flags_q <= {N{1'b0}};
      end else if (clear) begin
         flags_q <= events;
      end else begin
         flags_q <= flags_q | events;
      end
   end
endmodule // oc_flags

/* File: sim/host_model.sv */
// Host model that issues word reads and writes on the decoded access port.
// Assumes its tasks are called from one process only.
`timescale 1ns/1ps
module host_model #(
   parameter logic [7:0] KEY = 8'h5A
) (
   input logic ref_clk,
   input logic [31:0] reg_rdata_q,
   input logic reg_rvalid_q,
   output logic [15:0] reg_addr,
   output logic reg_wr,
   output logic reg_rd,
   output logic [31:0] reg_wdata
);
   initial begin
      reg_addr = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 32'h0000_0000;
   end
   // Address and data are inverted on release so stale values never look valid.
   task wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask
   task rd(input logic [15:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      @(posedge ref_clk);
      d = reg_rdata_q;
   endtask
   task protect(input logic [7:0] v);
      wr(16'hE7FE, {24'h00_0000, KEY});
      wr(16'hE7E3, {24'h00_0000, v});
   endtask
endmodule // host_model

/* File: sim/meter_regs_checker.sv */
// Checker of read answers, word formats, filter bypass, group select and pin enable.
// Assumes it is bound to the register bank and sees its ports by name.
`timescale 1ns/1ps
module meter_regs_checker (
   input logic ref_clk,
   input logic rstn,
   input logic [15:0] reg_addr,
   input logic reg_rd,
   input logic reg_wr,
   input logic [31:0] reg_wdata,
   input logic [31:0] reg_rdata_q,
   input logic reg_rvalid_q,
   input logic spi_active,
   input logic ack_pin_oe_q,
   input logic hpf_bypass_q,
   input logic group_sel_q,
   input logic [7:0] sag_half_cycle_count_q,
   input logic soft_reset_q
);
   logic [15:0] ra_q;
   logic wq_q;
   logic wd7_q;
   wire rv = reg_rvalid_q;
   default clocking dc @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         ra_q <= 16'h0000;
         wq_q <= 1'b0;
         wd7_q <= 1'b0;
      end else begin
         ra_q <= reg_addr;
         wq_q <= reg_wr;
         wd7_q <= reg_wdata[7];
      end
   end
   property p_answer;
      (reg_rd |=> rv) and (!reg_rd |=> !rv);
   endproperty
   a_answer: assert property (p_answer) else $error("read answer late");
   property p_ocflags;
      rv && ra_q == 16'hE600 |-> reg_rdata_q[2:0] == 3'h0 && reg_rdata_q[31:6] == 26'h0;
   endproperty
   a_ocflags: assert property (p_ocflags) else $error("flag word bad");
   property p_current_peak_capture;
      rv && ra_q == 16'hE500 |-> $onehot0(reg_rdata_q[26:24]) && reg_rdata_q[31:27] == 5'h0
         && (reg_rdata_q[23:0] == 24'h0 || reg_rdata_q[26:24] != 3'h0);
   endproperty
   a_current_peak_capture: assert property (p_current_peak_capture) else $error("current peak word bad");
   property p_voltage_peak_capture;
      rv && ra_q == 16'hE501 |-> reg_rdata_q[31:24] == 8'h00;
   endproperty
   a_voltage_peak_capture: assert property (p_voltage_peak_capture) else $error("voltage peak top byte");
   property p_sext;
      rv && ra_q inside {16'hE50C, 16'hE50D, 16'hE50E, 16'hE510}
         |-> reg_rdata_q[31:24] == {8{reg_rdata_q[23]}};
   endproperty
   a_sext: assert property (p_sext) else $error("no sign extension");
   property p_zpad;
      rv && ra_q == 16'h4389 |-> reg_rdata_q[31:24] == 8'h00;
   endproperty
   a_zpad: assert property (p_zpad) else $error("no zero padding");
   property p_gap;
      rv && ra_q >= 16'hE610 && ra_q <= 16'hE616 |-> reg_rdata_q == 32'h0000_0000;
   endproperty
   a_gap: assert property (p_gap) else $error("reserved gap nonzero");
   property p_bypass;
      rv && ra_q == 16'h4389 |-> hpf_bypass_q == (reg_rdata_q != 32'h0000_0000);
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass mismatch");
   property p_group;
      rv && ra_q == 16'hE60E |-> group_sel_q == reg_rdata_q[14];
   endproperty
   a_group: assert property (p_group) else $error("group select mismatch");
   property p_sag;
      rv && ra_q == 16'hE704 && !wq_q |-> sag_half_cycle_count_q == reg_rdata_q[7:0];
   endproperty
   a_sag: assert property (p_sag) else $error("sag count mismatch");
   property p_pin;
      !spi_active ##1 !spi_active |-> !ack_pin_oe_q;
   endproperty
   a_pin: assert property (p_pin) else $error("pin driven without serial port");
   // A software reset may only follow a configuration write with the reset bit set.
   property p_srst;
      soft_reset_q |-> wq_q && ra_q == 16'hE618 && wd7_q;
   endproperty
   a_srst: assert property (p_srst) else $error("soft reset without request");
   c_peak: cover property (rv && ra_q == 16'hE500 && reg_rdata_q[26]);
   c_pin: cover property ($rose(ack_pin_oe_q));
   c_srst: cover property (soft_reset_q);
endmodule // meter_regs_checker

/* File: sim/meter_regs_tb_top.sv */
// Testbench of the register bank: reset values, peaks, flags, formats, lock, pin.
// Assumes the host model drives the access port; the bench drives measurements.
`timescale 1ns/1ps
module meter_regs_tb_top;
   logic ref_clk, rstn, reg_wr, reg_rd, reg_rvalid_q, cur_valid, volt_valid, half_cycle;
   logic spi_active, ack_pin_o_q, ack_pin_oe_q, hpf_bypass_q, group_sel_q, soft_reset_q;
   logic [15:0] reg_addr, configuration_q, power_sign_flags;
   logic [31:0] reg_wdata, reg_rdata_q, got;
   logic [143:0] cur_mag, cur_wave;
   logic [23:0] volt_mag, volt_wave;
   logic [5:0] oc_event;
   logic [7:0] measurement_mode_q, accumulation_mode_q, line_cycle_accum_mode_q;
   logic [7:0] sag_half_cycle_count_q, capture_port_config_q, secondary_configuration_q;
   // The pin has a pull-up, so it reads high whenever nobody drives it.
   wire ack_pin_i = ack_pin_oe_q ? ack_pin_o_q : 1'b1;
   int fail_count, comparisons, i;
   logic [15:0] ra [12] = '{16'h4389, 16'hE60E, 16'hE618, 16'hE700, 16'hE701, 16'hE702,
      16'hE703, 16'hE704, 16'hE706, 16'hE707, 16'hE7E3, 16'hEC00};
   logic [15:0] rv [12] = '{16'h0000, 16'h01FF, 16'h0000, 16'h001C, 16'h0000, 16'h0078,
      16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0000, 16'h0000};
   meter_regs u_dut (.*);
   host_model u_host (.*);
   task ck(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task rc(input logic [15:0] a, input logic [31:0] e);
      u_host.rd(a, got);
      ck(got, e);
   endtask
   task tend(input string n);
      $display("test %0s ended, %0d mismatches so far", n, fail_count);
   endtask
   task pulse_hc;
      @(posedge ref_clk);
      half_cycle <= 1'b1;
      @(posedge ref_clk);
      half_cycle <= 1'b0;
   endtask
   task samp(input logic [143:0] m);
      @(posedge ref_clk);
      cur_mag <= m;
      cur_valid <= 1'b1;
      volt_valid <= 1'b1;
      @(posedge ref_clk);
      cur_valid <= 1'b0;
      volt_valid <= 1'b0;
   endtask
   task oc(input logic [5:0] e);
      @(posedge ref_clk);
      oc_event <= e;
      @(posedge ref_clk);
      oc_event <= 6'h00;
   endtask
   task test_done;
      $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   initial begin
      repeat (5000) @(posedge ref_clk);
      fail_count++;
      $display("[FAIL] t=%0t watchdog expired", $time);
      test_done;
   end
   initial begin
      rstn = 1'b0;
      cur_valid = 1'b0;
      volt_valid = 1'b0;
      half_cycle = 1'b0;
      spi_active = 1'b0;
      oc_event = 6'h00;
      cur_mag = 144'h0;
      volt_mag = 24'h12_3456;
      cur_wave = {120'h0, 24'h80_0001};
      volt_wave = 24'h7F_FFFF;
      power_sign_flags = 16'h0055;
      repeat (16) @(posedge ref_clk);
      rstn <= 1'b1;
      for (i = 0; i < 12; i++) rc(ra[i], {16'h0000, rv[i]});
      ck({configuration_q, measurement_mode_q, line_cycle_accum_mode_q}, 32'h0000_1C78);
      ck({accumulation_mode_q, capture_port_config_q, secondary_configuration_q, 8'h00}, 32'h0);
      tend("reset");
      u_host.wr(16'hE703, 32'h0000_0002);
      u_host.wr(16'hE704, 32'h0000_00A5);
      rc(16'hE703, 32'h0000_0002);
      rc(16'hE704, 32'h0000_00A5);
      ck({24'h00_0000, sag_half_cycle_count_q}, 32'h0000_00A5);
      rc(16'hE617, 32'h0000_0055);
      for (i = 16'hE610; i <= 16'hE616; i++) rc(i[15:0], 32'h0000_0000);
      rc(16'hE705, 32'h0000_0000);
      rc(16'hE50C, 32'hFF80_0001);
      rc(16'hE510, 32'h007F_FFFF);
      u_host.wr(16'h4389, 32'hFFFF_FFFF);
      rc(16'h4389, 32'h00FF_FFFF);
      ck({31'h0, hpf_bypass_q}, 32'h0000_0001);
      u_host.wr(16'h4389, 32'hFF00_0000);
      rc(16'h4389, 32'h0000_0000);
      ck({31'h0, hpf_bypass_q}, 32'h0000_0000);
      tend("registers");
      samp({48'h0, 24'h00_0070, 24'h00_0020, 24'h00_0030, 24'h00_0010});
      pulse_hc;
      pulse_hc;
      rc(16'hE500, 32'h0200_0030);
      rc(16'hE501, 32'h0012_3456);
      oc(6'h02);
      rc(16'hE600, 32'h0000_0010);
      rc(16'hE600, 32'h0000_0000);
      u_host.wr(16'hE60E, 32'h0000_41FF);
      rc(16'hE60E, 32'h0000_41FF);
      ck({31'h0, group_sel_q}, 32'h0000_0001);
      samp({24'h00_0090, 96'h0, 24'h00_00FF});
      pulse_hc;
      pulse_hc;
      rc(16'hE500, 32'h0400_0090);
      oc(6'h21);
      rc(16'hE600, 32'h0000_0020);
      tend("peaks");
      u_host.wr(16'hE7E3, 32'h0000_0001);
      rc(16'hE7E3, 32'h0000_0000);
      u_host.protect(8'h01);
      rc(16'hE7E3, 32'h0000_0001);
      u_host.wr(16'hE703, 32'h0000_0007);
      rc(16'hE703, 32'h0000_0002);
      u_host.protect(8'h00);
      u_host.wr(16'hE703, 32'h0000_0007);
      rc(16'hE703, 32'h0000_0007);
      tend("protection");
      u_host.wr(16'hEBFF, 32'h0000_0002);
      rc(16'hEBFF, 32'h0000_0001);
      spi_active <= 1'b1;
      u_host.wr(16'hEBFF, 32'h0000_0002);
      rc(16'hEBFF, 32'h0000_0002);
      u_host.wr(16'hEBFF, 32'h0000_0003);
      rc(16'hEBFF, 32'h0000_0003);
      tend("pin");
      u_host.wr(16'hE706, 32'h0000_0033);
      @(posedge ref_clk);
      ck({24'h00_0000, capture_port_config_q}, 32'h0000_0033);
      u_host.wr(16'hE618, 32'h0000_0080);
      rc(16'hE703, 32'h0000_0000);
      rc(16'hE618, 32'h0000_0000);
      ck({configuration_q, measurement_mode_q, line_cycle_accum_mode_q}, 32'h0000_1C78);
      ck({accumulation_mode_q, capture_port_config_q, secondary_configuration_q, 8'h00}, 32'h0);
      tend("soft reset");
      test_done;
   end
endmodule // meter_regs_tb_top
bind meter_regs meter_regs_checker u_chk (.*);
